// ==== bench/smbus_master_model.sv ====
// Purpose: Behavioural bus host master that drives the bus clock and pulls data low.
// Assumes: The data wire has a pull-up, so a released line reads high.
// Notes:   Tasks are called by the bench; signals move just after clk_sys edges.
`timescale 1ns/1ps
module smbus_master_model (
  // Clock.
  input wire logic clk_sys,
  // Bus lines.
  input wire logic sda_line,
  output logic scl_out,
  output logic sda_low
);
  // Extra high-phase cycles; lets the bench play a slow master.
  int slow = 0;

  // Idle bus: clock high, data released.
  initial begin
    scl_out = 1'b1;
    sda_low = 1'b0;
  end

  // -------------------------------------------------------------------
  // Bit level
  // -------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Data moves mid low phase and is sampled two cycles before the clock falls.
  task automatic put_bit(input logic b, output logic r);
    sda_low <= ~b;
    tick(2);
    scl_out <= 1'b1;
    tick(2 + slow);
    r = sda_line;
    tick(2);
    scl_out <= 1'b0;
    tick(2);
  endtask

  // Data falls while the clock is high; also serves as repeated start.
  task automatic start_cond();
    sda_low <= 1'b0;
    tick(4);
    scl_out <= 1'b1;
    tick(4);
    sda_low <= 1'b1;
    tick(4);
    scl_out <= 1'b0;
    tick(2);
  endtask

  // Data low in the low phase, then released while the clock is high.
  task automatic stop_cond();
    sda_low <= 1'b1;
    tick(4);
    scl_out <= 1'b1;
    tick(4);
    sda_low <= 1'b0;
    tick(4);
  endtask

  // -------------------------------------------------------------------
  // Byte level
  // -------------------------------------------------------------------
  // Eight bits, most significant first, then the slave's acknowledge.
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) put_bit(d[i], r);
    put_bit(1'b1, r);
    ack = ~r;
  endtask

  // Eight bits in, then acknowledge or a high no-acknowledge.
  task automatic recv_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
    put_bit(nack, r);
  endtask
endmodule // smbus_master_model

// ==== bench/smbus_slave_register_access_tb.sv ====
// Purpose: Self-checking bench for the serial management slave.
// Assumes: A behavioural master and a plain register file sit around the block.
// Notes:   Random pointers and data come from a fixed seed, so runs repeat.
`timescale 1ns/1ps
module smbus_slave_register_access_tb;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic strap_sense_up = 1'b0;
  logic strap_sense_down = 1'b0;
  logic [7:0] int_status = 8'h00;
  logic scl_in, sda_low, sda_out, sda_oe, reg_wr_en;
  logic [7:0] reg_pointer, reg_wr_data, reg_rd_data;
  logic [6:0] slave_address, my_addr;
  logic [7:0] regs [256];
  wire logic sda_line;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  integer seed = 41810;
  localparam int LIMIT = 20000;

  // -------------------------------------------------------------------
  // Environment
  // -------------------------------------------------------------------
  always #20 clk_sys = ~clk_sys;

  // Open-drain wire with pull-up: low whenever either party pulls it.
  assign sda_line = ~sda_low & (sda_oe ? sda_out : 1'b1);
  assign reg_rd_data = regs[reg_pointer];

  // Register file behind the block takes one write per strobe.
  always @(posedge clk_sys) if (reg_wr_en) regs[reg_pointer] <= reg_wr_data;

  smbus_slave_register_access #(.SYNC_STAGES(2)) smbus_slave_register_access_i (
    .clk_sys(clk_sys), .reset(reset), .scl_in(scl_in), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .strap_sense_up(strap_sense_up),
    .strap_sense_down(strap_sense_down), .reg_pointer(reg_pointer),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .int_status(int_status), .slave_address(slave_address));

  smbus_master_model smbus_master_model_i (
    .clk_sys(clk_sys), .sda_line(sda_line), .scl_out(scl_in), .sda_low(sda_low));

  // A hang is cut short so the run always reaches the verdict.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fail_count++;
      final_report();
    end
  end

  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  task automatic final_report();
    if (fail_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  // Strap code is {pull-up sense, pull-down sense}.
  function automatic logic [6:0] exp_addr(input logic [1:0] s);
    case (s)
      2'h0: return {5'h0B, 2'h2};
      2'h3: return {5'h0B, 2'h1};
      default: return {5'h0B, 2'h0};
    endcase
  endfunction

  task automatic do_reset(input logic [1:0] s);
    strap_sense_up <= s[1];
    strap_sense_down <= s[0];
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (10) @(posedge clk_sys);
  endtask

  // Write of n bytes; a holds the acks of address and bytes, MSB first.
  task automatic wr(input int n, input logic [7:0] p, input logic [7:0] d,
                    output logic [3:0] a);
    a = 4'h0;
    smbus_master_model_i.start_cond();
    smbus_master_model_i.send_byte({my_addr, 1'b0}, a[3]);
    smbus_master_model_i.send_byte(p, a[2]);
    if (n > 1) smbus_master_model_i.send_byte(d, a[1]);
    if (n > 2) smbus_master_model_i.send_byte(~d, a[0]);
    smbus_master_model_i.stop_cond();
  endtask

  // Single-byte read, optionally preceded by a pointer write and repeated start.
  task automatic rd(input logic use_ptr, input logic [7:0] p, output logic [7:0] v);
    logic a;
    smbus_master_model_i.start_cond();
    if (use_ptr) begin
      smbus_master_model_i.send_byte({my_addr, 1'b0}, a);
      smbus_master_model_i.send_byte(p, a);
      smbus_master_model_i.start_cond();
    end
    smbus_master_model_i.send_byte({my_addr, 1'b1}, a);
    smbus_master_model_i.recv_byte(1'b1, v);
    smbus_master_model_i.stop_cond();
    chk("read address ack", 8'h01, {7'h00, a});
  endtask

  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    logic [3:0] a;
    logic [7:0] p, d, v, o;
    for (int i = 0; i < 256; i++) regs[i] = 8'($random(seed));
    // Each strap code, then a strap change that must not move the address.
    for (int s = 0; s < 4; s++) begin
      do_reset(s[1:0]);
      chk("slave address", {1'b0, exp_addr(s[1:0])}, {1'b0, slave_address});
      strap_sense_up <= ~s[1];
      strap_sense_down <= ~s[0];
      repeat (10) @(posedge clk_sys);
      chk("held address", {1'b0, exp_addr(s[1:0])}, {1'b0, slave_address});
    end
    // Foreign address: no ack and no pointer change.
    my_addr = exp_addr(2'h3) ^ 7'h01;
    wr(2, 8'h10, 8'h55, a);
    chk("foreign ack", 8'h00, {4'h0, a});
    chk("pointer after foreign", 8'h00, reg_pointer);
    my_addr = exp_addr(2'h3);
    // Random writes and reads, alternating prompt and slow master.
    for (int k = 0; k < 6; k++) begin
      smbus_master_model_i.slow = (k % 2) * 3;
      p = 8'($random(seed));
      d = 8'($random(seed));
      if (p == 8'h4C) p = 8'h4D;
      wr(2, p, d, a);
      chk("write acks", 8'h07, {5'h00, a[3:1]});
      chk("pointer", p, reg_pointer);
      chk("written reg", d, regs[p]);
      o = regs[p ^ 8'h80];
      wr(1, p ^ 8'h80, 8'h00, a);
      chk("one-byte pointer", p ^ 8'h80, reg_pointer);
      chk("untouched reg", o, regs[p ^ 8'h80]);
      rd(1'b1, p, v);
      chk("read byte", d, v);
      rd(1'b0, p, v);
      chk("reread byte", d, v);
    end
    smbus_master_model_i.slow = 0;
    // Status mirror address returns the status input, not the file.
    int_status <= ~regs[8'h4C];
    @(posedge clk_sys);
    rd(1'b1, 8'h4C, v);
    chk("mirror", ~regs[8'h4C], v);
    // Third write byte is refused and writes nothing.
    wr(3, 8'h21, 8'hA5, a);
    chk("third byte acks", 8'h0E, {4'h0, a});
    chk("two-byte target", 8'hA5, regs[8'h21]);
    // Master acks the single read byte: the next byte reads released.
    smbus_master_model_i.start_cond();
    smbus_master_model_i.send_byte({my_addr, 1'b1}, a[0]);
    smbus_master_model_i.recv_byte(1'b0, v);
    smbus_master_model_i.recv_byte(1'b1, d);
    smbus_master_model_i.stop_cond();
    chk("single read", 8'hA5, v);
    chk("byte after single read", 8'hFF, d);
    final_report();
  end
endmodule // smbus_slave_register_access_tb

// ==== common/bus_events_if.sv ====
// Purpose: Carries conditioned bus-line events from the line conditioner.
// Assumes: All signals are one-cycle pulses or levels on clk_sys.
// Notes:   Source is the conditioner, sink is the sequencer.
`timescale 1ns/1ps
interface bus_events_if;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic sda_level;

  modport source (
    output scl_rise,
    output scl_fall,
    output start_seen,
    output stop_seen,
    output sda_level
  );

  modport sink (
    input scl_rise,
    input scl_fall,
    input start_seen,
    input stop_seen,
    input sda_level
  );
endinterface

// ==== common/smbus_consts.svh ====
// Purpose: Named constants for the serial management slave.
// Assumes: Included by bare name by every design file that needs them.
// Notes:   Definitions only; no logic lives here.
`ifndef SMBUS_CONSTS_SVH
`define SMBUS_CONSTS_SVH

// ----------------------------------------------------------------------
// Slave address
// ----------------------------------------------------------------------
`define SMB_ADDR_UPPER 5'h0B
`define SMB_STRAP_GND 2'h2
`define SMB_STRAP_VCC 2'h1
`define SMB_STRAP_OPEN 2'h0
`define SMB_STRAP_SETTLE 2'h3

// ----------------------------------------------------------------------
// Register access
// ----------------------------------------------------------------------
`define SMB_MIRROR_ADDR 8'h4C
`define SMB_PTR_RESET 8'h00
`define SMB_IDX_POINTER 2'h0
`define SMB_IDX_DATA 2'h1
`define SMB_WR_BYTES 2'h2

// ----------------------------------------------------------------------
// Framing
// ----------------------------------------------------------------------
`define SMB_BYTE_BITS 4'h8
`define SMB_BIT_ZERO 4'h0

`endif

// ==== common/smbus_pkg.sv ====
// Purpose: Types shared by the serial management slave.
// Assumes: Referenced as smbus_pkg::name, never imported.
// Notes:   Constants live in smbus_consts.svh.
package smbus_pkg;

  // Transfer sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WR_BYTE,
    ST_WR_ACK,
    ST_RD_BYTE,
    ST_RD_ACK,
    ST_IGNORE
  } bus_state_t;

endpackage

// ==== src/bus_line_conditioner.sv ====
// Purpose: Synchronises the bus clock and data lines and finds edges,
//          start and stop conditions.
// Assumes: The bus clock is slow against clk_sys (several cycles per phase).
// Notes:   Events are registered, so they lag the pins by a fixed latency.
`timescale 1ns/1ps
`include "smbus_consts.svh"
module bus_line_conditioner #(
  parameter int SYNC_STAGES = 2
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // Raw bus lines.
  input wire logic scl_in,
  input wire logic sda_in,
  // Conditioned events.
  bus_events_if.source ev
);

  // ----------------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------------
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES must be at least two");
  end

  logic [SYNC_STAGES-1:0] scl_sync_reg;
  logic [SYNC_STAGES-1:0] sda_sync_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;

  // Only the last stage is read, so the first flop never feeds logic.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      scl_sync_reg <= '1;
      sda_sync_reg <= '1;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[SYNC_STAGES-2:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[SYNC_STAGES-2:0], sda_in};
      scl_prev_reg <= scl_sync_reg[SYNC_STAGES-1];
      sda_prev_reg <= sda_sync_reg[SYNC_STAGES-1];
    end
  end

  // ----------------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------------
  // A data edge counts as start or stop only while the clock stays high
  // on both samples, which keeps ordinary data changes out.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ev.scl_rise <= 1'b0;
      ev.scl_fall <= 1'b0;
      ev.start_seen <= 1'b0;
      ev.stop_seen <= 1'b0;
      ev.sda_level <= 1'b1;
    end else begin
      ev.scl_rise <= scl_sync_reg[SYNC_STAGES-1] & ~scl_prev_reg;
      ev.scl_fall <= ~scl_sync_reg[SYNC_STAGES-1] & scl_prev_reg;
      ev.start_seen <= scl_sync_reg[SYNC_STAGES-1] & scl_prev_reg &
                       ~sda_sync_reg[SYNC_STAGES-1] & sda_prev_reg;
      ev.stop_seen <= scl_sync_reg[SYNC_STAGES-1] & scl_prev_reg &
                      sda_sync_reg[SYNC_STAGES-1] & ~sda_prev_reg;
      ev.sda_level <= sda_sync_reg[SYNC_STAGES-1];
    end
  end

endmodule // bus_line_conditioner

// ==== src/smbus_slave_register_access.sv ====
// Purpose: Serial management bus slave giving a bus master access to the
//          internal registers through an address pointer.
// Assumes: The register file sits outside and answers reg_rd_data for
//          reg_pointer combinationally on clk_sys.
// Notes:   Writes carry one or two bytes; reads return a single byte.
`timescale 1ns/1ps
`include "smbus_consts.svh"
// Function
// - Address upper bits fixed, low bits strapped.
// - Strap: ground 10, supply 01, open 00.
// - Strap latched once at power-up only.
// - Shift in address MSB first, then direction.
// - Acknowledge matching address on ninth pulse.
// - Mismatch: stay idle, bus undriven until start.
// - Direction zero writes, one reads.
// - Byte is eight bits plus acknowledge.
// - Data stable while clock high; rise means stop.
// - Direction fixed until new start.
// - Accept one or two written bytes, read one.
// - First written byte loads the pointer.
// - Second written byte goes to selected register.
// - One-byte write changes only the pointer.
// - Read returns register at current pointer.
// - Pointer write, repeated start, read supported.
// - Status also readable at mirror address.
module smbus_slave_register_access #(
  parameter int SYNC_STAGES = 2
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // Serial bus pins; data is open drain.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Three-level strap, sensed under weak pull-up and weak pull-down.
  input wire logic strap_sense_up,
  input wire logic strap_sense_down,
  // Internal register file port.
  output logic [7:0] reg_pointer,
  output logic reg_wr_en,
  output logic [7:0] reg_wr_data,
  input wire logic [7:0] reg_rd_data,
  input wire logic [7:0] int_status,
  // Observed slave address.
  output logic [6:0] slave_address
);

  // ----------------------------------------------------------------------
  // Line conditioning
  // ----------------------------------------------------------------------
  bus_events_if ev ();

  bus_line_conditioner #(
    .SYNC_STAGES(SYNC_STAGES)
  ) u_cond (
    .clk_sys(clk_sys),
    .reset(reset),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ev(ev)
  );

  // ----------------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------------
  logic [1:0] up_sync_reg;
  logic [1:0] down_sync_reg;
  logic [1:0] strap_wait_reg;
  logic strap_done_reg;
  logic [6:0] slave_address_reg;

  function automatic logic [1:0] strap_decode(input logic up, input logic down);
    logic [1:0] bits;
    bits = `SMB_STRAP_OPEN;
    case ({up, down})
      2'h0: bits = `SMB_STRAP_GND;
      2'h3: bits = `SMB_STRAP_VCC;
      default: bits = `SMB_STRAP_OPEN;
    endcase
    return bits;
  endfunction

  // Strap pins are asynchronous, so they pass two flops first.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      up_sync_reg <= 2'h0;
      down_sync_reg <= 2'h0;
    end else begin
      up_sync_reg <= {up_sync_reg[0], strap_sense_up};
      down_sync_reg <= {down_sync_reg[0], strap_sense_down};
    end
  end

  // The address is taken once, after the synchronisers have settled, and
  // then frozen until the next power-up reset.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      strap_wait_reg <= 2'h0;
      strap_done_reg <= 1'b0;
      slave_address_reg <= {`SMB_ADDR_UPPER, `SMB_STRAP_OPEN};
    end else if (!strap_done_reg) begin
      if (strap_wait_reg == `SMB_STRAP_SETTLE) begin
        strap_done_reg <= 1'b1;
        slave_address_reg <= {`SMB_ADDR_UPPER,
                              strap_decode(up_sync_reg[1], down_sync_reg[1])};
      end else begin
        strap_wait_reg <= strap_wait_reg + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------------
  smbus_pkg::bus_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [1:0] byte_idx_reg;
  logic rw_reg;
  logic [7:0] shift_in_reg;
  logic [7:0] tx_shift_reg;
  logic sda_oe_reg;
  logic [7:0] pointer_reg;
  logic wr_en_reg;
  logic [7:0] wr_data_reg;
  logic byte_done_fall;
  logic addr_match;
  logic [7:0] rd_byte;
  logic receiving;

  assign byte_done_fall = ev.scl_fall && (bit_cnt_reg == `SMB_BYTE_BITS);
  assign addr_match = strap_done_reg && (shift_in_reg[7:1] == slave_address_reg);
  // The mirror address always shows live status.
  assign rd_byte = (pointer_reg == `SMB_MIRROR_ADDR) ? int_status : reg_rd_data;
  assign receiving = (state_reg == smbus_pkg::ST_ADDR) ||
                     (state_reg == smbus_pkg::ST_WR_BYTE);

  // Bits are sampled on clock rise; the sender changes data only while
  // the clock is low, so the rise is the safe point.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      shift_in_reg <= 8'h00;
    end else if (ev.scl_rise && receiving && bit_cnt_reg != `SMB_BYTE_BITS) begin
      shift_in_reg <= {shift_in_reg[6:0], ev.sda_level};
    end
  end

  // Main sequencer: a start always restarts it, so a repeated start
  // after a pointer write opens a fresh read phase.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg <= smbus_pkg::ST_IDLE;
      bit_cnt_reg <= `SMB_BIT_ZERO;
      byte_idx_reg <= `SMB_IDX_POINTER;
      rw_reg <= 1'b0;
      tx_shift_reg <= 8'h00;
      sda_oe_reg <= 1'b0;
    end else if (ev.start_seen) begin
      state_reg <= smbus_pkg::ST_ADDR;
      bit_cnt_reg <= `SMB_BIT_ZERO;
      byte_idx_reg <= `SMB_IDX_POINTER;
      sda_oe_reg <= 1'b0;
    end else if (ev.stop_seen) begin
      state_reg <= smbus_pkg::ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      if (ev.scl_rise && bit_cnt_reg != `SMB_BYTE_BITS &&
          (receiving || state_reg == smbus_pkg::ST_RD_BYTE)) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
      case (state_reg)
        smbus_pkg::ST_ADDR: begin
          if (byte_done_fall) begin
            if (addr_match) begin
              state_reg <= smbus_pkg::ST_ADDR_ACK;
              sda_oe_reg <= 1'b1;
              rw_reg <= shift_in_reg[0];
            end else begin
              state_reg <= smbus_pkg::ST_IGNORE;
            end
          end
        end
        smbus_pkg::ST_ADDR_ACK: begin
          if (ev.scl_fall) begin
            bit_cnt_reg <= `SMB_BIT_ZERO;
            if (rw_reg) begin
              state_reg <= smbus_pkg::ST_RD_BYTE;
              tx_shift_reg <= rd_byte;
              sda_oe_reg <= ~rd_byte[7];
            end else begin
              state_reg <= smbus_pkg::ST_WR_BYTE;
              sda_oe_reg <= 1'b0;
            end
          end
        end
        smbus_pkg::ST_WR_BYTE: begin
          if (byte_done_fall) begin
            if (byte_idx_reg < `SMB_WR_BYTES) begin
              state_reg <= smbus_pkg::ST_WR_ACK;
              sda_oe_reg <= 1'b1;
            end else begin
              state_reg <= smbus_pkg::ST_IGNORE;
            end
          end
        end
        smbus_pkg::ST_WR_ACK: begin
          if (ev.scl_fall) begin
            state_reg <= smbus_pkg::ST_WR_BYTE;
            sda_oe_reg <= 1'b0;
            bit_cnt_reg <= `SMB_BIT_ZERO;
            byte_idx_reg <= byte_idx_reg + 2'h1;
          end
        end
        smbus_pkg::ST_RD_BYTE: begin
          if (ev.scl_fall) begin
            if (bit_cnt_reg == `SMB_BYTE_BITS) begin
              state_reg <= smbus_pkg::ST_RD_ACK;
              sda_oe_reg <= 1'b0;
            end else begin
              tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
              sda_oe_reg <= ~tx_shift_reg[6];
            end
          end
        end
        smbus_pkg::ST_RD_ACK: begin
          // Only one byte is served; acknowledge or not, the line stays
          // released until the master closes the transfer.
          if (ev.scl_rise) begin
            state_reg <= smbus_pkg::ST_IGNORE;
          end
        end
        default: begin
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Pointer and register writes
  // ----------------------------------------------------------------------
  // The pointer is touched only by the first byte of a write and holds
  // otherwise, so a later read can rely on it.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pointer_reg <= `SMB_PTR_RESET;
      wr_en_reg <= 1'b0;
      wr_data_reg <= 8'h00;
    end else begin
      wr_en_reg <= 1'b0;
      if (state_reg == smbus_pkg::ST_WR_BYTE && byte_done_fall && !ev.start_seen &&
          !ev.stop_seen) begin
        if (byte_idx_reg == `SMB_IDX_POINTER) begin
          pointer_reg <= shift_in_reg;
        end else if (byte_idx_reg == `SMB_IDX_DATA) begin
          wr_en_reg <= 1'b1;
          wr_data_reg <= shift_in_reg;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Open drain: the line is only ever pulled low.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  assign sda_oe = sda_oe_reg;
  assign reg_pointer = pointer_reg;
  assign reg_wr_en = wr_en_reg;
  assign reg_wr_data = wr_data_reg;
  assign slave_address = slave_address_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  logic first_wr_fall;
  assign first_wr_fall = state_reg == smbus_pkg::ST_WR_BYTE && byte_done_fall &&
                         !ev.start_seen && !ev.stop_seen;

  property p_upper_fixed;
    strap_done_reg |-> slave_address_reg[6:2] == `SMB_ADDR_UPPER;
  endproperty
  a_upper_fixed: assert property (p_upper_fixed) else $error("upper address wrong");

  property p_strap_decode;
    $rose(strap_done_reg) |-> slave_address_reg[1:0] ==
      {!$past(up_sync_reg[1]) && !$past(down_sync_reg[1]),
       $past(up_sync_reg[1]) && $past(down_sync_reg[1])};
  endproperty
  a_strap_decode: assert property (p_strap_decode) else $error("strap decode wrong");

  property p_strap_locked;
    strap_done_reg |=> strap_done_reg && $stable(slave_address_reg);
  endproperty
  a_strap_locked: assert property (p_strap_locked) else $error("address changed");

  property p_ack_match;
    state_reg == smbus_pkg::ST_ADDR && byte_done_fall && addr_match &&
      !ev.start_seen && !ev.stop_seen |=> sda_oe_reg && rw_reg == $past(shift_in_reg[0]);
  endproperty
  a_ack_match: assert property (p_ack_match) else $error("no address ack");

  property p_idle_quiet;
    (state_reg == smbus_pkg::ST_IGNORE || state_reg == smbus_pkg::ST_IDLE) |-> !sda_oe_reg;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("drove while idle");

  property p_pointer_load;
    first_wr_fall && byte_idx_reg == `SMB_IDX_POINTER |=>
      pointer_reg == $past(shift_in_reg) && !wr_en_reg;
  endproperty
  a_pointer_load: assert property (p_pointer_load) else $error("pointer not loaded");

  property p_data_write;
    first_wr_fall && byte_idx_reg == `SMB_IDX_DATA |=>
      wr_en_reg && wr_data_reg == $past(shift_in_reg) && $stable(pointer_reg);
  endproperty
  a_data_write: assert property (p_data_write) else $error("data not written");

  property p_write_cause;
    wr_en_reg |-> $past(byte_idx_reg) == `SMB_IDX_DATA;
  endproperty
  a_write_cause: assert property (p_write_cause) else $error("stray write");

  property p_mirror;
    state_reg == smbus_pkg::ST_ADDR_ACK && rw_reg && ev.scl_fall && !ev.start_seen &&
      !ev.stop_seen && pointer_reg == `SMB_MIRROR_ADDR |=> tx_shift_reg == $past(int_status);
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror data wrong");

  property p_msb_first;
    state_reg == smbus_pkg::ST_RD_BYTE && bit_cnt_reg != `SMB_BYTE_BITS |->
      sda_oe_reg == ~tx_shift_reg[7];
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("read bit order wrong");

  property p_stop_idle;
    ev.stop_seen && !ev.start_seen |=> state_reg == smbus_pkg::ST_IDLE ##1 !sda_oe_reg;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not honoured");

  c_two_byte_write: cover property (wr_en_reg);
  c_read_byte: cover property (state_reg == smbus_pkg::ST_RD_ACK);
  c_mismatch: cover property (state_reg == smbus_pkg::ST_ADDR ##1
                              state_reg == smbus_pkg::ST_IGNORE);
  c_repeated_start: cover property (state_reg == smbus_pkg::ST_WR_BYTE && ev.start_seen);

endmodule // smbus_slave_register_access
